/* hdl/dram_timing_pkg.sv */
// timing constants, cycle counts and types for the page-mode dram host
// assumes a 125 MHz controller clock; figures are those of the fastest grade
package dram_timing_pkg;
    localparam int CLK_NS = 8;
    // least times round up to whole clock cycles
    function automatic int up(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction
    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction
    // one speed grade: every figure below belongs to it
    localparam int T_RAH_NS = 10;
    localparam int T_RCD_MIN_NS = 20;
    localparam int T_RAC_NS = 60;
    localparam int T_RC_NS = 120;
    localparam int T_RAS_NS = 60;
    localparam int T_RAS_RMW_NS = 85;
    localparam int T_RMWC_NS = 140;
    localparam int T_CWL_NS = 15;
    localparam int T_RP_NS = 50;
    localparam int T_CP_NS = 10;
    localparam int T_CPRH_NS = 35;
    localparam int T_CSR_NS = 10;
    localparam int T_CHR_NS = 10;
    localparam int T_CAS_CBR_NS = 25;
    localparam int T_RAS_PAGE_MAX_NS = 200000;
    localparam int T_REF_NS = 16400000;
    localparam int REF_ROWS = 1024;
    localparam int SYNC_C = 2;
    localparam logic [3:0] INIT_CYCLES = 4'h8;
    // cycle counts
    localparam logic [4:0] RAH_C = 5'(up(T_RAH_NS));
    localparam logic [4:0] ROW_C = 5'(up(T_RCD_MIN_NS) + 1);
    localparam logic [4:0] CAS_RD_C = 5'(up(T_RAC_NS) + SYNC_C - 3);
    localparam logic [4:0] CAS_WR_C = 5'(up(T_RAS_NS) - 3);
    localparam logic [4:0] WRT_C =
        5'(max2(up(T_CWL_NS), up(T_RAS_RMW_NS) - 3 - int'(CAS_RD_C)));
    localparam logic [4:0] CP_C = 5'(up(T_CP_NS));
    localparam logic [4:0] CPRH_C = 5'(up(T_CPRH_NS));
    localparam logic [4:0] RP_C = 5'(up(T_RP_NS));
    localparam logic [4:0] CSR_C = 5'(up(T_CSR_NS));
    localparam logic [4:0] CHR_C =
        5'(max2(up(T_CHR_NS), up(T_CAS_CBR_NS) - int'(CSR_C)));
    localparam logic [4:0] RHOLD_C = 5'(up(T_RAS_NS) - int'(CHR_C));
    // longest times round down
    localparam int REF_INT_C = T_REF_NS / REF_ROWS / CLK_NS;
    localparam int RAS_PAGE_MAX_C = T_RAS_PAGE_MAX_NS / CLK_NS;
    localparam int PAGE_GUARD_C = 32;

    typedef enum logic [1:0] {
        K_READ = 2'h0,
        K_WRITE = 2'h1,
        K_RMW = 2'h2
    } kind_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ROW = 4'h1,
        S_COL = 4'h2,
        S_WRT = 4'h3,
        S_PAGE = 4'h4,
        S_PCOL = 4'h5,
        S_PRE = 4'h6,
        S_RCAS = 4'h7,
        S_RRAS = 4'h8,
        S_RHOLD = 4'h9
    } state_t;
endpackage

/* hdl/dram_host.sv */
// host controller for a 4M x 1 fast-page dram: read, early write,
// read-modify-write, page hits and column-first refresh
// assumes a 125 MHz clock and the dram's data output on dram_q_in
// no power-up pause is made here; the system must provide it
// Operation
// - write strobe high before column strobe falls
// - write strobe high through read end
// - write strobe low 10 ns past column fall
// - both strobes low 15 ns after write
// - write data valid around the later fall
// - read-modify-write timing minimums respected
// - page accesses at least 40 ns apart
// - page read-write accesses 60 ns apart
// - row strobe low time bounded
// - column precharge at least 10 ns
// - row low 35 ns after last precharge
// - column address held till near row rise
// - row/column strobe overlap minimums
// - column strobe timing for column-first refresh
// - write strobe high around refresh row fall
// - eight column-first refreshes before use
// - strobe levels select cycle type
// - all 1024 rows refreshed every 16.4 ms
`timescale 1ns/100ps
module dram_host #(
    parameter int ROW_W = 11,
    parameter int COL_W = 11,
    parameter int RAS_PAGE_MAX = dram_timing_pkg::RAS_PAGE_MAX_C,
    parameter int REF_INT = dram_timing_pkg::REF_INT_C
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire dram_timing_pkg::kind_t req_kind_in,
    input wire logic [ROW_W+COL_W-1:0] req_addr_in,
    input wire logic req_wdata_in,
    output logic rsp_valid_out,
    output logic rsp_data_out,
    output logic init_done_out,
    output logic dram_ras_n_out,
    output logic dram_cas_n_out,
    output logic dram_we_n_out,
    output logic [ROW_W-1:0] dram_addr_out,
    output logic dram_d_out,
    input wire logic dram_q_in
);
    import dram_timing_pkg::*;

    // sequencer state and dwell count
    state_t state;
    state_t next_state;
    logic [4:0] cnt;
    // row-open time and refresh interval timers
    logic [15:0] ras_time;
    logic [15:0] ref_timer;
    logic ref_due;
    logic [3:0] init_left;
    // captured request fields
    logic [ROW_W-1:0] cur_row;
    logic [COL_W-1:0] cur_col;
    kind_t cur_kind;
    // read data synchroniser
    logic q_meta;
    logic q_sync;
    // request decode
    logic page_hit;
    logic accept;
    logic wr_kind;

    // a page hit must leave room for one more access under the row limit
    assign page_hit = req_valid_in && !ref_due &&
        (req_addr_in[ROW_W+COL_W-1:COL_W] == cur_row) &&
        (ras_time < 16'(RAS_PAGE_MAX - PAGE_GUARD_C));
    assign req_ready_out = (state == S_IDLE && init_done_out && !ref_due) ||
        (state == S_PAGE && cnt >= CP_C - 5'h01 && page_hit);
    assign accept = req_valid_in && req_ready_out;
    assign wr_kind = (cur_kind == K_WRITE);

    // sequencing; each state but S_IDLE and S_PAGE stays a fixed count, so pin widths are exact
    always_comb begin
        next_state = state;
        case (state)
            // refresh and init win over a waiting request
            S_IDLE: begin
                if (!init_done_out || ref_due) begin
                    next_state = S_RCAS;
                end else if (req_valid_in) begin
                    next_state = S_ROW;
                end
            end
            // row strobe low; column goes out after the row hold
            S_ROW: begin
                if (cnt == ROW_C - 5'h01) begin
                    next_state = S_COL;
                end
            end
            // column strobe low; reads wait out the row access time
            S_COL: begin
                if (wr_kind && cnt == CAS_WR_C - 5'h01) begin
                    next_state = S_PAGE;
                end else if (!wr_kind && cnt == CAS_RD_C - 5'h01) begin
                    // rmw drops write strobe only after the read is taken
                    next_state = (cur_kind == K_RMW) ? S_WRT : S_PAGE;
                end
            end
            // late write strobe with both strobes still low
            S_WRT: begin
                if (cnt == WRT_C - 5'h01) begin
                    next_state = S_PAGE;
                end
            end
            // column precharge; a same-row request may reopen it
            S_PAGE: begin
                if (cnt >= CP_C - 5'h01 && page_hit) begin
                    next_state = S_PCOL;
                end else if (cnt >= CPRH_C - 5'h01) begin
                    next_state = S_PRE;
                end
            end
            // one cycle of column setup before the strobe falls
            S_PCOL: begin
                next_state = S_COL;
            end
            // row precharge; also spaces random cycles apart
            S_PRE: begin
                if (cnt == RP_C - 5'h01) begin
                    next_state = S_IDLE;
                end
            end
            // column strobe leads the row strobe for refresh
            S_RCAS: begin
                if (cnt == CSR_C - 5'h01) begin
                    next_state = S_RRAS;
                end
            end
            // row strobe low while the column strobe is still held
            S_RRAS: begin
                if (cnt == CHR_C - 5'h01) begin
                    next_state = S_RHOLD;
                end
            end
            // column released; row stays low for its minimum width
            S_RHOLD: begin
                if (cnt == RHOLD_C - 5'h01) begin
                    next_state = S_PRE;
                end
            end
            // unused codes fall back to idle
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // state register and dwell counter
    // the counter restarts on every change of state
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= S_IDLE;
            cnt <= 5'h00;
        end else begin
            state <= next_state;
            cnt <= (next_state != state) ? 5'h00 : cnt + 5'h01;
        end
    end

    // strobes follow the next state so they change on the same edge
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dram_ras_n_out <= 1'b1;
            dram_cas_n_out <= 1'b1;
            dram_we_n_out <= 1'b1;
        end else begin
            // row strobe low in every state that holds the row open
            dram_ras_n_out <= !(next_state inside {S_ROW, S_COL, S_WRT,
                S_PAGE, S_PCOL, S_RRAS, S_RHOLD});
            // column strobe low in access and refresh states
            dram_cas_n_out <= !(next_state inside {S_COL, S_WRT,
                S_RCAS, S_RRAS});
            // early write: strobe low already before column fall
            if (next_state == S_WRT) begin
                dram_we_n_out <= 1'b0;
            end else if (next_state inside {S_ROW, S_PCOL, S_COL}) begin
                dram_we_n_out <= !(accept ? req_kind_in == K_WRITE
                    : wr_kind);
            end else begin
                dram_we_n_out <= 1'b1;
            end
        end
    end

    // multiplexed address; column set two cycles before column strobe, one on page hits
    // trade-off: page hits reuse the open row, so only a column is driven
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dram_addr_out <= '0;
        end else if (accept && state == S_IDLE) begin
            dram_addr_out <= req_addr_in[ROW_W+COL_W-1:COL_W];
        end else if (accept) begin
            dram_addr_out <= ROW_W'(req_addr_in[COL_W-1:0]);
        end else if (state == S_ROW && cnt == RAH_C - 5'h01) begin
            dram_addr_out <= ROW_W'(cur_col);
        end
        // column stays put until the row strobe rises
    end

    // request capture; write data held until the next request
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cur_row <= '0;
            cur_col <= '0;
            cur_kind <= K_READ;
            dram_d_out <= 1'b0;
        end else if (accept) begin
            cur_row <= req_addr_in[ROW_W+COL_W-1:COL_W];
            cur_col <= req_addr_in[COL_W-1:0];
            cur_kind <= req_kind_in;
            dram_d_out <= req_wdata_in;
        end
    end

    // data output is an async pin: two flops before use
    // only q_sync is read, never q_meta
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            q_meta <= 1'b0;
            q_sync <= 1'b0;
        end else begin
            q_meta <= dram_q_in;
            q_sync <= q_meta;
        end
    end

    // sample late in the column phase; row access bounds the wait
    // the pin is seen two cycles late; the sample still follows row access
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rsp_valid_out <= 1'b0;
            rsp_data_out <= 1'b0;
        end else begin
            rsp_valid_out <= 1'b0;
            if (state == S_COL && !wr_kind && cnt == CAS_RD_C - 5'h01) begin
                rsp_valid_out <= 1'b1;
                rsp_data_out <= q_sync;
            end
        end
    end

    // row-low time, for the page limit
    // restarts when a new row opens; refresh time is never compared
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ras_time <= 16'h0000;
        end else if (state == S_ROW && cnt == 5'h00) begin
            ras_time <= 16'h0001;
        end else if (!dram_ras_n_out) begin
            ras_time <= ras_time + 16'h0001;
        end
    end

    // one row per interval; a tick landing on the take still counts
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ref_timer <= 16'h0000;
            ref_due <= 1'b0;
        end else begin
            if (ref_timer == 16'(REF_INT - 1)) begin
                ref_timer <= 16'h0000;
                ref_due <= 1'b1;
            end else begin
                ref_timer <= ref_timer + 16'h0001;
                // clear only on the take, so a new tick is never lost
                if (state == S_IDLE && next_state == S_RCAS) begin
                    ref_due <= 1'b0;
                end
            end
        end
    end

    // initialization count of column-first cycles
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            init_left <= INIT_CYCLES;
            init_done_out <= 1'b0;
        end else if (state == S_RHOLD && next_state == S_PRE &&
                     !init_done_out) begin
            init_left <= init_left - 4'h1;
            init_done_out <= (init_left == 4'h1);
        end
    end
    // timing counts all from one package set; RAS_PAGE_MAX and REF_INT can be overridden
endmodule // dram_host

/* tb/dram_model.sv */
// behavioural 4M x 1 page-mode dram seen from its pins
// assumes the host strobes are registered and glitch free
`timescale 1ns/100ps
module dram_model (
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [10:0] addr_in,
    input wire logic d_in,
    output logic q_out
);
    bit mem [int];
    int row;
    int key;
    int n_cbr;
    int early_use;
    realtime t_ras;
    initial begin
        q_out = 1'b0;
        n_cbr = 0;
        early_use = 0;
    end
    // column strobe already low at row fall means refresh, not an access
    always @(negedge ras_n_in) begin
        t_ras = $realtime;
        // row and strobe leave the host on one edge; read once both settle
        #1;
        if (cas_n_in) row = addr_in;
        else n_cbr++;
    end
    // access time is fixed here at the column access figure
    always @(negedge cas_n_in) begin
        if (!ras_n_in) begin
            key = (row << 11) | addr_in;
            if (n_cbr < 8) early_use++;
            if (!we_n_in) mem[key] = d_in;
            else #15 q_out = mem.exists(key) ? mem[key] : 1'b0;
        end
    end
    // a write strobe that comes too soon leaves the output garbled
    always @(negedge we_n_in) begin
        if (!cas_n_in && !ras_n_in) begin
            if ($realtime - t_ras < 60) q_out = ~q_out;
            mem[key] = d_in;
        end
    end
    // released output shows the inverse of the last bit, never a hold
    always @(posedge cas_n_in) q_out = ~q_out;
endmodule // dram_model

/* tb/dram_host_checker.sv */
// strobe timing assertions for the dram host
// assumes it is bound onto dram_host and sees only its ports
`timescale 1ns/100ps
module dram_host_checker #(
    parameter int ROW_W = 11,
    parameter int RAS_PAGE_MAX = 100,
    parameter int REF_INT = 200
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic init_done_out,
    input wire logic dram_ras_n_out,
    input wire logic dram_cas_n_out,
    input wire logic dram_we_n_out,
    input wire logic [ROW_W-1:0] dram_addr_out
);
    int ras_low;
    int since_ref;
    int n_ref;
    logic cas_q;
    wire logic ref_go = cas_q && !dram_cas_n_out && dram_ras_n_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    // cycle counters; an access under way can hold off refresh, since page hits stop once it is due, hence the slack
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cas_q <= 1'b1;
            ras_low <= 0;
            since_ref <= 0;
            n_ref <= 0;
        end else begin
            cas_q <= dram_cas_n_out;
            ras_low <= dram_ras_n_out ? 0 : ras_low + 1;
            since_ref <= ref_go ? 0 : since_ref + 1;
            n_ref <= n_ref + int'(ref_go);
        end
    end
    sequence s_cbr; $fell(dram_cas_n_out) && dram_ras_n_out; endsequence
    sequence s_col; $fell(dram_cas_n_out) && !dram_ras_n_out; endsequence
    property p_cbr_ras; s_cbr |-> dram_ras_n_out[*2] ##1 !dram_ras_n_out;
    endproperty
    property p_cbr_cas; s_cbr |-> (!dram_cas_n_out)[*4] ##1 dram_cas_n_out;
    endproperty
    property p_cbr_we; s_cbr |-> dram_we_n_out[*5]; endproperty
    property p_rc; $fell(dram_ras_n_out) |=> (!$fell(dram_ras_n_out))[*7]
        ##1 (!$fell(dram_ras_n_out))[*7]; endproperty
    property p_csh; $fell(dram_ras_n_out) && dram_cas_n_out
        |-> (!dram_ras_n_out)[*8]; endproperty
    property p_rsh; s_col |=> ($stable(dram_addr_out) && !dram_ras_n_out)[*3];
    endproperty
    property p_wch; (s_col and !dram_we_n_out) |-> (!dram_we_n_out)[*2];
    endproperty
    property p_cwl; $fell(dram_we_n_out) && !dram_cas_n_out
        |-> (!dram_cas_n_out && !dram_ras_n_out)[*2]; endproperty
    property p_cp; $rose(dram_cas_n_out) && !dram_ras_n_out |=> dram_cas_n_out;
    endproperty
    property p_pc; s_col |=> (!$fell(dram_cas_n_out))[*4]; endproperty
    property p_ras_max; ras_low <= RAS_PAGE_MAX; endproperty
    property p_ref; since_ref <= REF_INT + RAS_PAGE_MAX + 40; endproperty
    property p_init; $rose(init_done_out) |-> n_ref == 8; endproperty
    a_cbr_ras: assert property (p_cbr_ras) else $error("refresh row late");
    a_cbr_cas: assert property (p_cbr_cas) else $error("refresh cas width");
    a_cbr_we: assert property (p_cbr_we) else $error("refresh we low");
    a_rc: assert property (p_rc) else $error("row cycle short");
    a_csh: assert property (p_csh) else $error("row low short");
    a_rsh: assert property (p_rsh) else $error("col hold short");
    a_wch: assert property (p_wch) else $error("write hold short");
    a_cwl: assert property (p_cwl) else $error("strobes after we");
    a_cp: assert property (p_cp) else $error("cas precharge short");
    a_pc: assert property (p_pc) else $error("page cycle short");
    a_ras_max: assert property (p_ras_max) else $error("row open long");
    a_ref: assert property (p_ref) else $error("refresh late");
    a_init: assert property (p_init) else $error("init count");
endmodule // dram_host_checker
bind dram_host dram_host_checker #(.ROW_W(ROW_W),
    .RAS_PAGE_MAX(RAS_PAGE_MAX), .REF_INT(REF_INT)) u_chk (
    .clock_in(clock_in), .arst_n_in(arst_n_in),
    .init_done_out(init_done_out), .dram_ras_n_out(dram_ras_n_out),
    .dram_cas_n_out(dram_cas_n_out), .dram_we_n_out(dram_we_n_out),
    .dram_addr_out(dram_addr_out));

/* tb/dram_host_tb.sv */
// self-checking bench: random reads, writes and rmw against a bit map
// assumes dram_model on the pins and a 125 MHz clock
`timescale 1ns/100ps
module dram_host_tb;
    import dram_timing_pkg::*;
    logic clock_in, arst_n_in, req_valid_in, req_wdata_in, dram_q_in;
    logic req_ready_out, rsp_valid_out, rsp_data_out, init_done_out;
    logic dram_ras_n_out, dram_cas_n_out, dram_we_n_out, dram_d_out;
    logic [10:0] dram_addr_out;
    logic [21:0] req_addr_in;
    kind_t req_kind_in;
    int n_errors, num_checks, seed, base, r;
    bit ref_mem [int];
    dram_host #(.RAS_PAGE_MAX(100), .REF_INT(200)) u_dut (
        .clock_in(clock_in), .arst_n_in(arst_n_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_kind_in(req_kind_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .init_done_out(init_done_out),
        .dram_ras_n_out(dram_ras_n_out), .dram_cas_n_out(dram_cas_n_out),
        .dram_we_n_out(dram_we_n_out), .dram_addr_out(dram_addr_out),
        .dram_d_out(dram_d_out), .dram_q_in(dram_q_in));
    dram_model u_mem (.ras_n_in(dram_ras_n_out), .cas_n_in(dram_cas_n_out),
        .we_n_in(dram_we_n_out), .addr_in(dram_addr_out), .d_in(dram_d_out),
        .q_out(dram_q_in));
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_int(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait at falling edges, where level outputs have settled
    task automatic wait_lvl(input int sel, input int lim);
        int w;
        w = 0;
        while (w < lim && (sel == 0 ? req_ready_out : sel == 1 ?
            rsp_valid_out : init_done_out) !== 1'b1) begin
            @(negedge clock_in);
            w++;
        end
        if (w >= lim) begin
            n_errors++;
            conclude();
        end
    endtask
    // one request held until taken; read data checked against the map
    task automatic issue(input kind_t kd, input logic [21:0] a, input logic wd);
        logic exp;
        exp = ref_mem.exists(a) ? ref_mem[a] : 1'b0;
        @(negedge clock_in);
        req_valid_in = 1'b1;
        req_kind_in = kd;
        req_addr_in = a;
        req_wdata_in = wd;
        #1 wait_lvl(0, 2000);
        @(negedge clock_in);
        req_valid_in = 1'b0;
        if (kd != K_READ) ref_mem[a] = wd;
        if (kd != K_WRITE) begin
            wait_lvl(1, 40);
            chk(rsp_data_out, exp);
        end
    endtask
    task automatic start(input int lim);
        arst_n_in = 1'b0;
        repeat (8) @(posedge clock_in);
        @(negedge clock_in) arst_n_in = 1'b1;
        wait_lvl(2, 400);
        chk_int(int'(u_mem.early_use), 0);
    endtask
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
    initial begin
        seed = 20;
        {req_valid_in, req_wdata_in, req_addr_in} = '0;
        req_kind_in = K_READ;
        start(400);
        // four rows only, so back-to-back hits exercise page mode
        for (int i = 0; i < 80; i++) begin
            r = xs();
            issue(kind_t'(r[21:20] == 2'h3 ? 2'h1 : r[21:20]),
                {9'h0, r[12:11], 7'h0, r[3:0]}, r[7]);
            if (i == 40) begin
                base = u_mem.n_cbr;
                repeat (700) @(negedge clock_in);
                chk_int(int'(u_mem.n_cbr - base >= 3), 1);
                start(400);
            end
        end
        conclude();
    end
endmodule // dram_host_tb
